/* File: hw/pwm_unit_pkg.sv */
package pwm_unit_pkg;

  // Register indices; the byte address on the bus is four times the index
  localparam logic [7:0] WIDE_DUTY_HIGH_IDX = 8'hF0;
  localparam logic [7:0] WIDE_DUTY_LOW_IDX  = 8'hF1;
  localparam logic [7:0] NARROW_DUTY_A_IDX  = 8'hF2;
  localparam logic [7:0] NARROW_DUTY_B_IDX  = 8'hF3;
  localparam logic [7:0] OUTPUT_SELECT_IDX  = 8'hF5;
  localparam logic [7:0] PORT_SIX_DIR_IDX   = 8'hEF;
  localparam int         ADDR_W             = 10;
  localparam int         BYTE_SHIFT         = 2;

  // Field layout
  localparam int WIDE_W        = 14;
  localparam int FINE_W        = 6;
  localparam int COARSE_W      = 8;
  localparam int NARROW_W      = 6;
  localparam int PENDING_BIT   = 7;
  localparam int FIRST_PIN_BIT = 1;
  localparam int PIN_COUNT     = 3;

  // Reset values
  localparam logic [7:0]  REG_RESET  = 8'h00;
  localparam logic [13:0] WIDE_RESET = 14'h0000;

  // Timing: step is the main clock divided by 25, 500 ns at the reference rate
  localparam int SYS_CLK_MHZ    = 50;
  localparam int STEP_NS        = 500;
  localparam int STEP_CYC       = STEP_NS * SYS_CLK_MHZ / 1000;
  localparam int PRESCALE_W     = 5;
  localparam logic [4:0] PRESCALE_LAST = 5'(STEP_CYC - 1);

  // Wide period 8192 us = 64 short intervals of 256 steps (128 us)
  localparam int WIDE_PERIOD_US  = 8192;
  localparam int SHORT_PERIOD_US = 128;
  localparam logic [13:0] WIDE_LAST_STEP = 14'h3FFF;

  // Narrow period 1024 us = 64 segments of 16 us (32 steps)
  localparam int NARROW_PERIOD_US = 1024;
  localparam int NARROW_SEG_US    = 16;
  localparam logic [10:0] NARROW_LAST_STEP = 11'h7FF;

endpackage

/* File: hw/dual_resolution_pwm_unit.sv */
// How it works
// R1: One 14-bit and two 6-bit modulated outputs.
// R2: Wide step 500 ns, period 8192 us.
// R3: Narrow step 16 us, period 1024 us.
// R4: Shared timing from main clock divided by 25.
// R5: Software sets select and direction bits.
// R6: Software writes wide high byte, then low.
// R7: Narrow duty writes keep bits 0 to 5.
// R8: Registers copy into latches at period end.
// R9: Duty reads return latch contents.
// R10: Wide low bit 7 flags pending transfer.
// R11: Narrow period has 64 binary-weighted segments.
// R12: Narrow high time 0/64 to 63/64.
// R13: Wide latch splits coarse and fine.
// R14: Coarse value gives high steps per interval.
// R15: Fine bits add a step in chosen intervals.
// R16: Each interval high time is N or N+1.
// R17: Pins float after reset until enabled.
// R18: Low byte write arms wide transfer.
`timescale 1ns/1ps
module dual_resolution_pwm_unit
  import pwm_unit_pkg::*;
(
  // Clock and reset
  input  wire logic                 sys_clk,
  input  wire logic                 resetn,
  // Avalon-MM slave
  input  wire logic [ADDR_W-1:0]    address,
  input  wire logic                 read,
  input  wire logic                 write,
  input  wire logic [7:0]           writedata,
  output logic      [7:0]           readdata,
  output logic                      waitrequest,
  // Port six bits 1 to 3
  output logic      [PIN_COUNT-1:0] portSixOut,
  output logic      [PIN_COUNT-1:0] portSixOe
);

  logic [4:0]            prescale_r;
  logic                  stepTick;
  logic [WIDE_W-1:0]     stepCnt_r;
  logic                  wideEnd;
  logic                  narrowEnd;
  logic [7:0]            regIdx;
  logic                  mapped;
  logic                  accept;
  logic                  waitReq_r;
  logic [7:0]            readData_r;
  logic [7:0]            readData_nxt;
  logic [COARSE_W-1:0]   wideHigh_r;
  logic [FINE_W-1:0]     wideLow_r;
  logic [WIDE_W-1:0]     wideLatch_r;
  logic                  widePending_r;
  logic                  wideLowWrite;
  logic [NARROW_W-1:0]   narrowReg_r   [2];
  logic [NARROW_W-1:0]   narrowLatch_r [2];
  logic [1:0]            narrowPending_r;
  logic [1:0]            narrowRaw;
  logic [PIN_COUNT-1:0]  select_r;
  logic [PIN_COUNT-1:0]  direction_r;
  logic [PIN_COUNT-1:0]  pinLevel;
  logic [PIN_COUNT-1:0]  pinOut_r;
  logic [PIN_COUNT-1:0]  pinOe_r;
  logic                  wideRaw;
  logic                  wideExtra;
  logic [8:0]            wideHighSteps;
  logic [5:0]            interval;
  logic [7:0]            stepInInterval;
  logic [5:0]            segment;

  // Picks the duty bit owning a slot: lowest set bit k of the slot selects
  // bit 5-k, so slot 0 is never owned and a full-high period cannot occur.
  function automatic logic weightedBit(input logic [5:0] slot, input logic [5:0] duty);
    logic r;
    r = 1'b0;
    for (int k = 5; k >= 0; k--) begin
      if (slot[k]) begin
        r = duty[5-k];
      end
    end
    return r;
  endfunction

  // R4: clock divided by 25 as step
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      prescale_r <= 5'h00;
    end else if (prescale_r == PRESCALE_LAST) begin
      prescale_r <= 5'h00;
    end else begin
      prescale_r <= prescale_r + 5'h01;
    end
  end

  assign stepTick = (prescale_r == PRESCALE_LAST);

  // R2: one counter spans the wide period
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      stepCnt_r <= 14'h0000;
    end else if (stepTick) begin
      stepCnt_r <= stepCnt_r + 14'h0001;
    end
  end

  // R3: narrow period is the low eleven bits
  assign wideEnd   = stepTick && (stepCnt_r == WIDE_LAST_STEP);
  assign narrowEnd = stepTick && (stepCnt_r[10:0] == NARROW_LAST_STEP);

  // Bus decode; non-word-aligned addresses are unmapped
  assign regIdx = address[ADDR_W-1:BYTE_SHIFT];
  assign mapped = (address[BYTE_SHIFT-1:0] == 2'b00) &&
                  ((regIdx == WIDE_DUTY_HIGH_IDX) || (regIdx == WIDE_DUTY_LOW_IDX) ||
                   (regIdx == NARROW_DUTY_A_IDX)  || (regIdx == NARROW_DUTY_B_IDX) ||
                   (regIdx == OUTPUT_SELECT_IDX)  || (regIdx == PORT_SIX_DIR_IDX));
  assign accept = !waitReq_r && (read || write);

  // One wait cycle per access keeps waitrequest registered
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      waitReq_r <= 1'b1;
    end else begin
      waitReq_r <= !((read || write) && waitReq_r);
    end
  end

  // R9: duty reads show latches, not registers
  always_comb begin
    readData_nxt = 8'h00;
    if (mapped) begin
      case (regIdx)
        WIDE_DUTY_HIGH_IDX: readData_nxt = wideLatch_r[WIDE_W-1:FINE_W];
        // R10: pending flag in bit 7
        WIDE_DUTY_LOW_IDX:  readData_nxt = {widePending_r, 1'b0, wideLatch_r[FINE_W-1:0]};
        NARROW_DUTY_A_IDX:  readData_nxt = {2'b00, narrowLatch_r[0]};
        NARROW_DUTY_B_IDX:  readData_nxt = {2'b00, narrowLatch_r[1]};
        OUTPUT_SELECT_IDX:  readData_nxt = {4'h0, select_r, 1'b0};
        PORT_SIX_DIR_IDX:   readData_nxt = {4'h0, direction_r, 1'b0};
        default:            readData_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      readData_r <= REG_RESET;
    end else if (read && waitReq_r) begin
      readData_r <= readData_nxt;
    end
  end

  // R6: high byte is a plain store
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      wideHigh_r <= REG_RESET;
      wideLow_r  <= 6'h00;
    end else if (accept && write && mapped) begin
      if (regIdx == WIDE_DUTY_HIGH_IDX) begin
        wideHigh_r <= writedata;
      end
      if (regIdx == WIDE_DUTY_LOW_IDX) begin
        wideLow_r <= writedata[FINE_W-1:0];
      end
    end
  end

  assign wideLowWrite = accept && write && mapped && (regIdx == WIDE_DUTY_LOW_IDX);

  // R18: low write arms; a write in the boundary cycle stays armed
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      widePending_r <= 1'b0;
    end else if (wideLowWrite) begin
      widePending_r <= 1'b1;
    end else if (wideEnd) begin
      widePending_r <= 1'b0;
    end
  end

  // R8: wide transfer at period repeat
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      wideLatch_r <= WIDE_RESET;
    end else if (wideEnd && widePending_r) begin
      wideLatch_r <= {wideHigh_r, wideLow_r};
    end
  end

  assign segment = stepCnt_r[10:5];

  generate
    for (genvar c = 0; c < 2; c++) begin : g_narrow
      logic chanWrite;
      assign chanWrite = accept && write && mapped &&
                         (regIdx == (NARROW_DUTY_A_IDX + 8'(c)));

      // R7: upper two bits dropped
      always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
          narrowReg_r[c] <= 6'h00;
        end else if (chanWrite) begin
          narrowReg_r[c] <= writedata[NARROW_W-1:0];
        end
      end

      // R8: latch moves only after a write
      always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
          narrowPending_r[c] <= 1'b0;
        end else if (chanWrite) begin
          narrowPending_r[c] <= 1'b1;
        end else if (narrowEnd) begin
          narrowPending_r[c] <= 1'b0;
        end
      end

      // R8: narrow transfer at period repeat
      always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
          narrowLatch_r[c] <= 6'h00;
        end else if (narrowEnd && narrowPending_r[c]) begin
          narrowLatch_r[c] <= narrowReg_r[c];
        end
      end

      // R11: binary-weighted segment selection
      // R12: segment 0 never high
      assign narrowRaw[c] = weightedBit(segment, narrowLatch_r[c]);
    end
  endgenerate

  // R13: coarse and fine split
  assign interval       = stepCnt_r[13:8];
  assign stepInInterval = stepCnt_r[7:0];
  // R15: fine bit owns chosen intervals
  assign wideExtra      = weightedBit(interval, wideLatch_r[FINE_W-1:0]);
  // R14: coarse steps every interval
  // R16: plus at most one step
  assign wideHighSteps  = {1'b0, wideLatch_r[WIDE_W-1:FINE_W]} + {8'h00, wideExtra};
  assign wideRaw        = ({1'b0, stepInInterval} < wideHighSteps);

  // R1: three waveforms to pins
  assign pinLevel = {narrowRaw[1], narrowRaw[0], wideRaw};

  // R5: select and direction registers
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      select_r    <= 3'h0;
      direction_r <= 3'h0;
    end else if (accept && write && mapped) begin
      if (regIdx == OUTPUT_SELECT_IDX) begin
        select_r <= writedata[FIRST_PIN_BIT +: PIN_COUNT];
      end
      if (regIdx == PORT_SIX_DIR_IDX) begin
        direction_r <= writedata[FIRST_PIN_BIT +: PIN_COUNT];
      end
    end
  end

  generate
    for (genvar p = 0; p < PIN_COUNT; p++) begin : g_pin
      // R17: pin floats until both bits set
      always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
          pinOut_r[p] <= 1'b0;
          pinOe_r[p]  <= 1'b0;
        end else begin
          pinOut_r[p] <= pinLevel[p];
          pinOe_r[p]  <= select_r[p] && direction_r[p];
        end
      end
    end
  endgenerate

  assign readdata    = readData_r;
  assign waitrequest = waitReq_r;
  assign portSixOut  = pinOut_r;
  assign portSixOe   = pinOe_r;

  accept_pulse_a: assert property (@(posedge sys_clk) disable iff (!resetn) // R4
    !waitReq_r |=> waitReq_r)
    else $error("waitrequest low for more than one cycle");

  step_spacing_a: assert property (@(posedge sys_clk) disable iff (!resetn) // R4
    stepTick |=> !stepTick [*8])
    else $error("step tick came too soon");

  arm_on_low_a: assert property (@(posedge sys_clk) disable iff (!resetn) // R18
    wideLowWrite |=> widePending_r)
    else $error("low byte write did not arm transfer");

  pending_clear_a: assert property (@(posedge sys_clk) disable iff (!resetn) // R10
    (wideEnd && !wideLowWrite) |=> !widePending_r)
    else $error("pending flag not cleared at period end");

  wide_transfer_a: assert property (@(posedge sys_clk) disable iff (!resetn) // R8
    (wideEnd && widePending_r) |=> (wideLatch_r == {$past(wideHigh_r), $past(wideLow_r)}))
    else $error("wide latch missed the transfer");

  latch_hold_a: assert property (@(posedge sys_clk) disable iff (!resetn) // R8
    !wideEnd |=> $stable(wideLatch_r))
    else $error("wide latch changed mid period");

  narrow_never_full_a: assert property (@(posedge sys_clk) disable iff (!resetn) // R12
    (segment == 6'h00) |-> (narrowRaw == 2'b00))
    else $error("narrow output high in segment zero");

  wide_bound_a: assert property (@(posedge sys_clk) disable iff (!resetn) // R16
    ({1'b0, stepInInterval} > {1'b0, wideLatch_r[13:6]}) |-> !wideRaw)
    else $error("wide high time beyond coarse plus one");

  narrow_mask_a: assert property (@(posedge sys_clk) disable iff (!resetn) // R7
    (accept && write && mapped && regIdx == NARROW_DUTY_A_IDX)
      |=> (narrowReg_r[0] == $past(writedata[5:0])))
    else $error("narrow register did not keep low six bits");

  pin_float_a: assert property (@(posedge sys_clk) disable iff (!resetn) // R17
    !(select_r[0] && direction_r[0]) |=> !portSixOe[0])
    else $error("wide pin driven without select and direction");

  narrow_latch_hold_a: assert property (@(posedge sys_clk) disable iff (!resetn) // R8
    !narrowEnd |=> $stable(narrowLatch_r[0]))
    else $error("narrow latch changed mid period");

  narrow_transfer_a: assert property (@(posedge sys_clk) disable iff (!resetn) // R8
    (narrowEnd && narrowPending_r[0]) |=> (narrowLatch_r[0] == $past(narrowReg_r[0])))
    else $error("narrow latch missed the transfer");

  narrow_odd_seg_a: assert property (@(posedge sys_clk) disable iff (!resetn) // R11
    segment[0] |-> (narrowRaw[0] == narrowLatch_r[0][5]))
    else $error("odd segment not owned by top duty bit");

  pin_follow_a: assert property (@(posedge sys_clk) disable iff (!resetn) // R1
    1'b1 |=> (portSixOut == $past(pinLevel)))
    else $error("pin level does not follow waveform");

  pin_enable_a: assert property (@(posedge sys_clk) disable iff (!resetn) // R17
    1'b1 |=> (portSixOe == $past(select_r & direction_r)))
    else $error("pin enable does not follow select and direction");

  latch_read_a: assert property (@(posedge sys_clk) disable iff (!resetn) // R9
    (read && waitReq_r && mapped && regIdx == NARROW_DUTY_B_IDX)
      |=> (readdata == {2'b00, $past(narrowLatch_r[1])}))
    else $error("narrow read did not return latch");

  pending_read_a: assert property (@(posedge sys_clk) disable iff (!resetn) // R10
    (read && waitReq_r && mapped && regIdx == WIDE_DUTY_LOW_IDX)
      |=> (readdata[PENDING_BIT] == $past(widePending_r)))
    else $error("low byte read did not show pending flag");

endmodule

/* File: test/dual_resolution_pwm_unit_test.sv */
`timescale 1ns/1ps
module dual_resolution_pwm_unit_test;
  import pwm_unit_pkg::*;
  logic                 sys_clk = 1'b0;
  logic                 resetn = 1'b0;
  logic [ADDR_W-1:0]    address = '0;
  logic                 read = 1'b0;
  logic                 write = 1'b0;
  logic [7:0]           writedata = 8'h00;
  logic [7:0]           readdata;
  logic                 waitrequest;
  logic [PIN_COUNT-1:0] portSixOut;
  logic [PIN_COUNT-1:0] portSixOe;
  int                   err_count = 0;
  int                   checks_done = 0;

  // 50 MHz sys_clk
  localparam int NARROW_CYC = 2048 * STEP_CYC;
  localparam int SEG_CYC    = 32 * STEP_CYC;

  dual_resolution_pwm_unit DUT (
    .sys_clk     (sys_clk),
    .resetn      (resetn),
    .address     (address),
    .read        (read),
    .write       (write),
    .writedata   (writedata),
    .readdata    (readdata),
    .waitrequest (waitrequest),
    .portSixOut  (portSixOut),
    .portSixOe   (portSixOe)
  );

  initial begin
    forever #10 sys_clk = ~sys_clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] expected);
    checks_done++;
    if (seen !== expected) begin
      err_count++;
      $display("mismatch at %0t: seen %0h expected %0h", $time, seen, expected);
    end
  endtask

  task automatic complete_run();
    $display("errors %0d checks %0d", err_count, checks_done);
    if (err_count == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // One Avalon access; request held until waitrequest is sampled low
  // A slave that never answers is caught by the watchdog, not here
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
                     output logic [7:0] rd);
    @(posedge sys_clk);
    read      <= ~wr;
    write     <= wr;
    address   <= {idx, 2'b00};
    writedata <= wd;
    do begin
      @(posedge sys_clk);
    end while (waitrequest !== 1'b0);
    rd = readdata;
    read  <= 1'b0;
    write <= 1'b0;
  endtask

  task automatic wr_reg(input logic [7:0] idx, input logic [7:0] wd);
    logic [7:0] dummy;
    bus(1'b1, idx, wd, dummy);
  endtask

  task automatic rd_check(input logic [7:0] idx, input logic [7:0] expected);
    logic [7:0] rd;
    bus(1'b0, idx, 8'h00, rd);
    check({24'h0, rd}, {24'h0, expected});
  endtask

  // Pins float and latches read zero before anything is written
  task automatic test_reset_state();
    check({29'h0, portSixOe}, 32'h0);
    rd_check(WIDE_DUTY_HIGH_IDX, 8'h00);
    rd_check(WIDE_DUTY_LOW_IDX, 8'h00);
    rd_check(NARROW_DUTY_A_IDX, 8'h00);
    rd_check(NARROW_DUTY_B_IDX, 8'h00);
    rd_check(8'h10, 8'h00);
  endtask

  // Reads show latches, not registers; low write raises pending
  task automatic test_write_pending();
    wr_reg(NARROW_DUTY_A_IDX, 8'hFF);
    wr_reg(NARROW_DUTY_B_IDX, 8'hC5);
    wr_reg(WIDE_DUTY_HIGH_IDX, 8'hAB);
    wr_reg(WIDE_DUTY_LOW_IDX, 8'h15);
    wr_reg(8'h10, 8'h55);
    rd_check(NARROW_DUTY_A_IDX, 8'h00);
    rd_check(WIDE_DUTY_HIGH_IDX, 8'h00);
    rd_check(WIDE_DUTY_LOW_IDX, 8'h80);
  endtask

  // Select and direction together drive the three pins
  task automatic test_pin_enable();
    wr_reg(OUTPUT_SELECT_IDX, 8'h0E);
    check({29'h0, portSixOe}, 32'h0);
    wr_reg(PORT_SIX_DIR_IDX, 8'h0E);
    repeat (3) @(posedge sys_clk);
    check({29'h0, portSixOe}, 32'h7);
    rd_check(OUTPUT_SELECT_IDX, 8'h0E);
  endtask

  // Narrow latches load at the period end; high time over one whole period
  task automatic test_narrow_period();
    logic [7:0] rd;
    int         hiW;
    int         hiA;
    int         hiB;
    rd = 8'h00;
    // Polls until the latch loads; a load that never comes is left to the watchdog
    while (rd !== 8'h3F) begin
      bus(1'b0, NARROW_DUTY_A_IDX, 8'h00, rd);
    end
    check({24'h0, rd}, 32'h3F);
    rd_check(NARROW_DUTY_B_IDX, 8'h05);
    rd_check(WIDE_DUTY_LOW_IDX, 8'h80);
    rd_check(WIDE_DUTY_HIGH_IDX, 8'h00);
    hiW = 0;
    hiA = 0;
    hiB = 0;
    repeat (NARROW_CYC) begin
      @(posedge sys_clk);
      // An unknown level counts as high so it cannot pass the zero check
      hiW += (portSixOut[0] !== 1'b0);
      hiA += (portSixOut[1] === 1'b1);
      hiB += (portSixOut[2] === 1'b1);
    end
    check(32'(hiA), 32'(63 * SEG_CYC));
    check(32'(hiB), 32'(5 * SEG_CYC));
    check(32'(hiW), 32'h0);
    check({29'h0, portSixOe}, 32'h7);
  endtask

  // A reset in mid-run floats the pins and clears latches and pending flag
  task automatic test_mid_reset();
    @(posedge sys_clk);
    resetn <= 1'b0;
    @(posedge sys_clk);
    check({29'h0, portSixOe}, 32'h0);
    resetn <= 1'b1;
    rd_check(NARROW_DUTY_A_IDX, 8'h00);
    rd_check(WIDE_DUTY_LOW_IDX, 8'h00);
    check({29'h0, portSixOe}, 32'h0);
  endtask

  initial begin
    #3000000;
    check(32'h1, 32'h0);
    complete_run();
  end

  initial begin
    repeat (4) @(posedge sys_clk);
    resetn <= 1'b1;
    test_reset_state();
    test_write_pending();
    test_pin_enable();
    test_narrow_period();
    test_mid_reset();
    complete_run();
  end
endmodule
